// >>> logic/temp_alert_pkg.sv
// Shared constants, field layouts and types of the temperature limit-alert block
package temp_alert_pkg;

   // Register select codes carried by the pointer's two low bits
   localparam logic [1:0] PTR_TEMP  = 2'h0;
   localparam logic [1:0] PTR_CFG   = 2'h1;
   localparam logic [1:0] PTR_LOWER = 2'h2;
   localparam logic [1:0] PTR_UPPER = 2'h3;

   // Configuration word bit positions
   localparam int CFG_RATE_HI  = 14;
   localparam int CFG_RATE_LO  = 13;
   localparam int CFG_OVER     = 12;
   localparam int CFG_UNDER    = 11;
   localparam int CFG_THERM    = 10;
   localparam int CFG_MODE_HI  = 9;
   localparam int CFG_MODE_LO  = 8;
   localparam int CFG_POL      = 7;
   localparam int CFG_HYST_HI  = 5;
   localparam int CFG_HYST_LO  = 4;
   localparam int CODE_SHIFT   = 4;

   // Power-up values
   localparam logic [15:0] CFG_RESET   = 16'h2610;
   localparam logic [11:0] UPPER_RESET = 12'h7FF;
   localparam logic [11:0] LOWER_RESET = 12'h800;
   localparam logic [11:0] TEMP_RESET  = 12'h000;

   // Mode and hysteresis encodings
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_ONESHOT  = 2'h1;
   localparam logic [12:0] HYST_0C = 13'h0000;
   localparam logic [12:0] HYST_1C = 13'h0010;
   localparam logic [12:0] HYST_2C = 13'h0020;
   localparam logic [12:0] HYST_4C = 13'h0040;

   // Timing: conversion time and rate periods in microseconds, clock in MHz
   localparam longint CLK_MHZ        = 250;
   localparam longint CONV_TIME_US   = 22000;
   localparam longint PERIOD_R0_US   = 4000000;
   localparam longint PERIOD_R1_US   = 1000000;
   localparam longint PERIOD_R2_US   = 250000;
   localparam longint PERIOD_R3_US   = 62500;
   localparam int unsigned CONV_CYCLES  = int'(CONV_TIME_US * CLK_MHZ);
   localparam int unsigned STBY_R0_CYC  = int'((PERIOD_R0_US - CONV_TIME_US) * CLK_MHZ);
   localparam int unsigned STBY_R1_CYC  = int'((PERIOD_R1_US - CONV_TIME_US) * CLK_MHZ);
   localparam int unsigned STBY_R2_CYC  = int'((PERIOD_R2_US - CONV_TIME_US) * CLK_MHZ);
   localparam int unsigned STBY_R3_CYC  = int'((PERIOD_R3_US - CONV_TIME_US) * CLK_MHZ);

   // Kinds of request handed over by the two-wire slave logic
   typedef enum logic [1:0] {
      CMD_READ  = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_ALERT = 2'h2,
      CMD_GCRST = 2'h3
   } cmd_kind_t;

   typedef struct packed {
      cmd_kind_t   kind;
      logic [1:0]  ptr;
      logic [15:0] wdata;
   } link_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic [15:0] data;
   } link_rsp_t;

   // Conversion scheduler states
   typedef enum logic [2:0] {
      ST_CONVERT  = 3'b001,
      ST_STANDBY  = 3'b010,
      ST_SHUTDOWN = 3'b100
   } conv_state_t;

   typedef struct packed {
      logic [1:0] rate_sel;
      logic       over_limit_flag;
      logic       under_limit_flag;
      logic       thermostat_select;
      logic [1:0] conv_mode;
      logic       output_polarity;
      logic [1:0] hyst_sel;
   } cfg_t;

endpackage : temp_alert_pkg

// >>> logic/temp_limit_alert.sv
// Conversion scheduler, limit registers and alert logic of the temperature sensor
`timescale 1ns/1ns

// How it works
// R1: Result is a 12-bit code, 1/16 degree per count, in the top twelve bits.
// R2: Negative temperatures are two's complement codes with the top bit set.
// R3: Configuration is a 16-bit read/write word, power-up value 0x2610.
// R4: Hysteresis select 00/01/10/11 gives 0, 1, 2 or 4 degrees.
// R5: Alert pin is active low with polarity 0, active high with polarity 1.
// R6: Mode 00 shuts down after the running conversion ends; registers stay reachable.
// R7: Writing mode 01 in shutdown runs one conversion, then mode reads 00.
// R8: Continuous mode converts, then waits in standby for the rate delay.
// R9: Rate select 00/01/10/11 gives 0.25, 1, 4 or 16 conversions per second.
// R10: A conversion lasts 22 ms; the result is stored at its end.
// R11: A conversion starts right after reset and after general-call reset.
// R12: Thermostat bit 0 selects comparator mode, 1 selects interrupt mode.
// R13: At conversion end the over-limit flag sets when result exceeds upper limit.
// R14: At conversion end the under-limit flag sets when result is below lower limit.
// R15: In interrupt mode an alert response clears the pin but not the flags.
// R16: A configuration read clears flags and alert, except in comparator mode.
// R17: Comparator alert holds until result lies inside the hysteresis-narrowed window.
// R18: Interrupt alert latches until configuration read or alert response.
// R19: General-call reset deasserts the alert.
// R20: Upper limit resets to 0x7FF0 and lower limit to 0x8000.
// R21: Limits share the result format; low four bits of the word are zero.
// R22: Pointer low bits 00/01/10/11 select result, configuration, lower, upper.
// R23: Result reads zero after reset until the first conversion ends.
// R24: Alert response reports over-limit cause as a one, under-limit as zero.
// R25: General-call reset restores every register to its power-up value.
// R26: Comparisons are signed 12-bit; hysteresis is sixteen counts per degree.
// R27: Unused and fixed-zero bits are ignored on write and read as zero.
module temp_limit_alert
   import temp_alert_pkg::*;
#(
   parameter int unsigned CONV_CYC = temp_alert_pkg::CONV_CYCLES,
   parameter int unsigned STBY_R0  = temp_alert_pkg::STBY_R0_CYC,
   parameter int unsigned STBY_R1  = temp_alert_pkg::STBY_R1_CYC,
   parameter int unsigned STBY_R2  = temp_alert_pkg::STBY_R2_CYC,
   parameter int unsigned STBY_R3  = temp_alert_pkg::STBY_R3_CYC
) (
   // System clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      arst_n,
   // Two-wire slave side, on its own clock
   input  wire logic                      link_clk,
   input  wire logic                      cmd_valid,
   input  wire temp_alert_pkg::link_cmd_t cmd,
   output logic                           cmd_busy,
   output temp_alert_pkg::link_rsp_t      rsp,
   // Analog front end
   input  wire logic [11:0]               adc_code,
   output logic                           sensor_enable,
   // Alert pin level
   output logic                           alert_pin
);
   import temp_alert_pkg::*;

   // All system-domain state lives in one struct, so reset and registering stay in one place
   // and no field can be forgotten in either; the synchroniser stages are part of it as well,
   // which keeps every flop of this domain on the same clock and the same reset
   typedef struct packed {
      conv_state_t state;
      logic [31:0] timer;
      cfg_t        cfg;
      logic [11:0] temp;
      logic [11:0] upper;
      logic [11:0] lower;
      logic        alert_act;
      logic        alert_pin;
      logic        sens_en;
      logic [11:0] adc_s1;
      logic [11:0] adc_s2;
      logic        req_s1;
      logic        req_s2;
      logic        req_seen;
      logic        ack_tgl;
      logic        rsp_hit;
      logic [15:0] rsp_data;
   } sys_state_t;

   // Link-domain state: the held request, the request toggle and the answer side of the
   // handshake, all clocked by the two-wire slave's own clock
   typedef struct packed {
      link_cmd_t   hold;
      logic        req_tgl;
      logic        busy;
      logic        ack_s1;
      logic        ack_s2;
      logic        ack_seen;
      link_rsp_t   rsp;
   } link_state_t;

   sys_state_t  s_q, s_d;
   link_state_t l_q, l_d;

   // Power-up configuration taken apart from the host word; one value serves the asynchronous
   // reset and the general-call reset, so the two can never drift apart
   localparam cfg_t CFG_PWRUP = cfg_t'({CFG_RESET[CFG_RATE_HI:CFG_MODE_LO], CFG_RESET[CFG_POL],
                                         CFG_RESET[CFG_HYST_HI:CFG_HYST_LO]});

   // Hysteresis setting to counts, sixteen per degree
   function automatic logic [12:0] hyst_counts(input logic [1:0] sel);
      logic [12:0] h;
      case (sel)
         2'h0:    h = HYST_0C;  // R4
         2'h1:    h = HYST_1C;
         2'h2:    h = HYST_2C;
         default: h = HYST_4C;
      endcase
      return h;  // R26
   endfunction : hyst_counts

   // Sign-extend a 12-bit code so window edges never wrap
   function automatic logic signed [12:0] sx(input logic [11:0] v);
      return $signed({v[11], v});  // R26
   endfunction : sx

   // Configuration word as seen by the host
   function automatic logic [15:0] cfg_word(input cfg_t c);
      logic [15:0] w;
      w = 16'h0000;  // R27
      w[CFG_RATE_HI:CFG_RATE_LO] = c.rate_sel;
      w[CFG_OVER]                = c.over_limit_flag;
      w[CFG_UNDER]               = c.under_limit_flag;
      w[CFG_THERM]               = c.thermostat_select;
      w[CFG_MODE_HI:CFG_MODE_LO] = c.conv_mode;
      w[CFG_POL]                 = c.output_polarity;
      w[CFG_HYST_HI:CFG_HYST_LO] = c.hyst_sel;
      return w;  // R3
   endfunction : cfg_word

   // One step of the shared down-counter; callers test for the end first, so it never wraps
   function automatic logic [31:0] dec1(input logic [31:0] v);
      return v - 32'h0000_0001;
   endfunction : dec1

   // Standby length for the chosen rate
   function automatic logic [31:0] stby_cycles(input logic [1:0] rate);
      logic [31:0] c;
      case (rate)
         2'h0:    c = 32'(STBY_R0);  // R9
         2'h1:    c = 32'(STBY_R1);
         2'h2:    c = 32'(STBY_R2);
         default: c = 32'(STBY_R3);
      endcase
      return c;
   endfunction : stby_cycles

   // System domain: scheduler, registers, alert
   always_comb begin
      logic        req_new;
      logic        conv_done;
      logic        is_over;
      logic        is_under;
      logic        in_win;
      logic [12:0] h;
      logic [11:0] t;
      req_new   = 1'b0;
      conv_done = 1'b0;
      is_over   = 1'b0;
      is_under  = 1'b0;
      in_win    = 1'b0;
      h         = 13'h0000;
      t         = 12'h000;
      s_d       = s_q;

      // Front-end code and request toggle pass two flops before use
      // The code is several bits wide, so a sample taken while it moves may mix two values;
      // the front end holds it steady around conversion end, the only time it is used
      s_d.adc_s1 = adc_code;
      s_d.adc_s2 = s_q.adc_s1;
      s_d.req_s1 = l_q.req_tgl;
      s_d.req_s2 = s_q.req_s1;
      req_new    = s_q.req_s2 != s_q.req_seen;

      // Conversion scheduler
      // A general-call reset further down may still override the state chosen here
      case (s_q.state)
         ST_CONVERT: begin
            if (s_q.timer <= 32'h0000_0001) begin
               conv_done = 1'b1;  // R10
               if (s_q.cfg.conv_mode[1]) begin
                  s_d.state = ST_STANDBY;  // R8
                  s_d.timer = stby_cycles(s_q.cfg.rate_sel);
               end else begin
                  s_d.state = ST_SHUTDOWN;  // R6
                  s_d.cfg.conv_mode = MODE_SHUTDOWN;  // R7
               end
            end else begin
               s_d.timer = dec1(s_q.timer);
            end
         end
         // Standby leaves at once when continuous mode is dropped; there is nothing to finish
         ST_STANDBY: begin
            if (!s_q.cfg.conv_mode[1]) begin
               s_d.state = ST_SHUTDOWN;
            end else if (s_q.timer <= 32'h0000_0001) begin
               s_d.state = ST_CONVERT;  // R8
               s_d.timer = 32'(CONV_CYC);
            end else begin
               s_d.timer = dec1(s_q.timer);
            end
         end
         // Any non-zero mode wakes the scheduler; one-shot only gets here from shutdown
         ST_SHUTDOWN: begin
            if (s_q.cfg.conv_mode != MODE_SHUTDOWN) begin
               s_d.state = ST_CONVERT;  // R7
               s_d.timer = 32'(CONV_CYC);
            end
         end
         default: begin
            s_d.state = ST_CONVERT;
            s_d.timer = 32'(CONV_CYC);
         end
      endcase

      // Result capture and limit comparison at conversion end
      if (conv_done) begin
         t        = s_q.adc_s2;
         s_d.temp = t;  // R1 R2 R23
         h        = hyst_counts(s_q.cfg.hyst_sel);
         is_over  = sx(t) > sx(s_q.upper);  // R13 R26
         is_under = sx(t) < sx(s_q.lower);  // R14 R26
         in_win   = (sx(t) >= $signed(sx(s_q.lower) + $signed(h))) &&
                    (sx(t) <= $signed(sx(s_q.upper) - $signed(h)));  // R17
      end

      // Host request taken from the link side; done before flag updates so a new event wins
      if (req_new) begin
         s_d.req_seen = s_q.req_s2;
         s_d.ack_tgl  = ~s_q.ack_tgl;
         s_d.rsp_hit  = 1'b0;
         s_d.rsp_data = 16'h0000;
         case (l_q.hold.kind)
            CMD_READ: begin
               case (l_q.hold.ptr)  // R22
                  PTR_TEMP:  s_d.rsp_data = {s_q.temp, 4'h0};  // R1
                  PTR_CFG:   s_d.rsp_data = cfg_word(s_q.cfg);
                  PTR_LOWER: s_d.rsp_data = {s_q.lower, 4'h0};  // R21
                  default:   s_d.rsp_data = {s_q.upper, 4'h0};
               endcase
               if (l_q.hold.ptr == PTR_CFG && s_q.cfg.thermostat_select) begin
                  s_d.cfg.over_limit_flag  = 1'b0;  // R16
                  s_d.cfg.under_limit_flag = 1'b0;
                  s_d.alert_act            = 1'b0;
               end
            end
            CMD_WRITE: begin
               case (l_q.hold.ptr)  // R22
                  PTR_CFG: begin
                     // Flags and fixed-zero bits are not writable
                     s_d.cfg.rate_sel          = l_q.hold.wdata[CFG_RATE_HI:CFG_RATE_LO];  // R27
                     s_d.cfg.thermostat_select = l_q.hold.wdata[CFG_THERM];  // R12
                     s_d.cfg.output_polarity   = l_q.hold.wdata[CFG_POL];
                     s_d.cfg.hyst_sel          = l_q.hold.wdata[CFG_HYST_HI:CFG_HYST_LO];
                     // A one-shot request only counts when the scheduler is stopped
                     if (l_q.hold.wdata[CFG_MODE_HI:CFG_MODE_LO] != MODE_ONESHOT ||
                         s_q.state == ST_SHUTDOWN) begin
                        s_d.cfg.conv_mode = l_q.hold.wdata[CFG_MODE_HI:CFG_MODE_LO];  // R6 R7
                     end
                  end
                  PTR_LOWER: s_d.lower = l_q.hold.wdata[15:CODE_SHIFT];  // R21 R27
                  PTR_UPPER: s_d.upper = l_q.hold.wdata[15:CODE_SHIFT];  // R21 R27
                  default: ;  // Result register is read only
               endcase
            end
            CMD_ALERT: begin
               // Only a latched interrupt-mode alert answers; a comparator alert is a level
               if (s_q.alert_act && s_q.cfg.thermostat_select) begin
                  s_d.rsp_hit     = 1'b1;
                  s_d.rsp_data[0] = s_q.cfg.over_limit_flag;  // R24
                  s_d.alert_act   = 1'b0;  // R15
               end
            end
            default: begin
               s_d.cfg   = CFG_PWRUP;  // R25
               s_d.temp  = TEMP_RESET;
               s_d.upper = UPPER_RESET;
               s_d.lower = LOWER_RESET;
               s_d.alert_act = 1'b0;  // R19
               s_d.state = ST_CONVERT;  // R11
               s_d.timer = 32'(CONV_CYC);
            end
         endcase
      end

      // Flags and alert follow the conversion result; a set beats a same-cycle clear
      // A general-call reset in the same cycle wins instead, since it restarts the conversion
      if (conv_done && !(req_new && l_q.hold.kind == CMD_GCRST)) begin
         if (s_q.cfg.thermostat_select) begin
            if (is_over) begin
               s_d.cfg.over_limit_flag = 1'b1;  // R13
            end
            if (is_under) begin
               s_d.cfg.under_limit_flag = 1'b1;  // R14
            end
            if (is_over || is_under) begin
               s_d.alert_act = 1'b1;  // R18
            end
         end else begin
            if (is_over || is_under) begin
               s_d.alert_act = 1'b1;  // R17
               s_d.cfg.over_limit_flag  = is_over;
               s_d.cfg.under_limit_flag = is_under;
            end else if (in_win) begin
               s_d.alert_act = 1'b0;  // R17
               s_d.cfg.over_limit_flag  = 1'b0;
               s_d.cfg.under_limit_flag = 1'b0;
            end
         end
      end

      // Pin level from the next alert state so the pin stays a plain flop
      s_d.alert_pin = s_d.cfg.output_polarity ? s_d.alert_act : ~s_d.alert_act;  // R5
      s_d.sens_en   = s_d.state == ST_CONVERT;  // R6
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q           <= '0;
         s_q.state     <= ST_CONVERT;  // R11
         s_q.timer     <= 32'(CONV_CYC);
         s_q.cfg       <= CFG_PWRUP;  // R3
         s_q.temp      <= TEMP_RESET;  // R23
         s_q.upper     <= UPPER_RESET;  // R20
         s_q.lower     <= LOWER_RESET;  // R20
         // Pin idles high: the polarity field resets to active low
         s_q.alert_pin <= 1'b1;
         s_q.sens_en   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Link domain: hold one request, toggle it across, wait for the answer toggle
   // Only one request is ever in flight, so the held word and the answer word stay still
   // while the toggle crosses; that is what lets them cross without their own synchroniser
   always_comb begin
      l_d           = l_q;
      l_d.rsp.valid = 1'b0;
      l_d.ack_s1    = s_q.ack_tgl;
      l_d.ack_s2    = l_q.ack_s1;
      // Held fields stay still while busy, so the other side may read them after the toggle
      if (cmd_valid && !l_q.busy) begin
         l_d.hold    = cmd;
         l_d.req_tgl = ~l_q.req_tgl;
         l_d.busy    = 1'b1;
      end
      if (l_q.ack_s2 != l_q.ack_seen) begin
         l_d.ack_seen  = l_q.ack_s2;
         l_d.busy      = 1'b0;
         l_d.rsp.valid = 1'b1;
         l_d.rsp.hit   = s_q.rsp_hit;
         l_d.rsp.data  = s_q.rsp_data;
      end
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // Outputs straight from flops
   // No logic between a flop and a pin, so the pins never glitch
   assign cmd_busy      = l_q.busy;
   assign rsp           = l_q.rsp;
   assign sensor_enable = s_q.sens_en;
   assign alert_pin     = s_q.alert_pin;

endmodule : temp_limit_alert

// >>> tb/temp_alert_properties.sv
// Port timing checks of the temperature limit-alert block
`timescale 1ns/1ns
module temp_alert_props
   import temp_alert_pkg::*;
#(
   parameter int unsigned CONV_CYC = 20
) (
   // Clocks and reset
   input wire logic                      sys_clk,
   input wire logic                      arst_n,
   input wire logic                      link_clk,
   // Link side
   input wire logic                      cmd_valid,
   input wire temp_alert_pkg::link_cmd_t cmd,
   input wire logic                      cmd_busy,
   input wire temp_alert_pkg::link_rsp_t rsp,
   // Sensor and alert
   input wire logic [11:0]               adc_code,
   input wire logic                      sensor_enable,
   input wire logic                      alert_pin
);
   import temp_alert_pkg::*;
   // Cycles spent converting; cleared while idle so each run is measured alone
   logic [31:0] run_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) run_q <= '0;
      else if (sensor_enable) run_q <= run_q + 32'h0000_0001;
      else run_q <= '0;
   end
   sequence take_s;
      cmd_valid && !cmd_busy;
   endsequence
   sequence answer_s;
      ##[3:12] rsp.valid;
   endsequence
   busy_take_a: assert property (
      @(posedge link_clk) disable iff (!arst_n) take_s |=> cmd_busy) else $error("busy missing");
   answer_bound_a: assert property (
      @(posedge link_clk) disable iff (!arst_n) take_s |-> answer_s) else $error("no answer");
   rsp_pulse_a: assert property (
      @(posedge link_clk) disable iff (!arst_n) rsp.valid |=> !rsp.valid) else $error("long answer");
   busy_clear_a: assert property (
      @(posedge link_clk) disable iff (!arst_n) $fell(cmd_busy) |-> rsp.valid) else $error("busy drop");
   rsp_hold_a: assert property (
      @(posedge link_clk) disable iff (!arst_n) !rsp.valid |-> $stable(rsp.data) && $stable(rsp.hit))
      else $error("answer data moved");
   rsp_cause_a: assert property (
      @(posedge link_clk) disable iff (!arst_n) rsp.valid |-> $past(cmd_busy)) else $error("stray answer");
   conv_min_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n) $rose(sensor_enable) |-> sensor_enable[*8])
      else $error("conversion too short");
   conv_len_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(sensor_enable) |-> run_q >= CONV_CYC - 1 && run_q <= CONV_CYC + 1)
      else $error("conversion length wrong");
endmodule : temp_alert_props

bind temp_limit_alert temp_alert_props #(.CONV_CYC(CONV_CYC)) u_props (
   .sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
   .cmd_busy(cmd_busy), .rsp(rsp), .adc_code(adc_code), .sensor_enable(sensor_enable),
   .alert_pin(alert_pin));

// >>> tb/temp_host_model.sv
// Two-wire host model handing whole register requests to the block
`timescale 1ns/1ns
module temp_host_model
   import temp_alert_pkg::*;
(
   // Link clock and answer
   input  wire logic                      link_clk,
   input  wire logic                      cmd_busy,
   input  wire temp_alert_pkg::link_rsp_t rsp,
   // Request
   output logic                           cmd_valid,
   output temp_alert_pkg::link_cmd_t      cmd
);
   import temp_alert_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // Held until taken, then fields flipped so a stale word is never read twice
   task automatic xfer(input cmd_kind_t k, input logic [1:0] p, input logic [15:0] w,
                       output link_rsp_t r);
      int n;
      n = 0;
      @(posedge link_clk);
      #1;
      while (cmd_busy !== 1'b0) begin
         @(posedge link_clk);
         #1;
      end
      cmd_valid = 1'b1;
      cmd = '{kind: k, ptr: p, wdata: w};
      @(posedge link_clk);
      #1;
      cmd_valid = 1'b0;
      cmd.ptr = ~p;
      cmd.wdata = ~w;
      while (rsp.valid !== 1'b1 && n < 30) begin
         @(posedge link_clk);
         #1;
         n++;
      end
      r = rsp;
   endtask : xfer
endmodule : temp_host_model

// >>> tb/temp_limit_alert_bench.sv
// Self-checking bench of the temperature limit-alert block
`timescale 1ns/1ns
module temp_limit_alert_bench;
   import temp_alert_pkg::*;
   localparam int unsigned CONV = 60;
   localparam int unsigned SB[4] = '{40, 30, 20, 10};
   logic        sys_clk  = 1'b0;
   logic        link_clk = 1'b0;
   logic        arst_n   = 1'b0;
   logic [11:0] adc_code = 12'h4B0;
   logic        cmd_valid, cmd_busy, sensor_enable, alert_pin;
   link_cmd_t   cmd;
   link_rsp_t   rsp, r;
   int          n_fail   = 0;
   int          n_tests  = 0;
   // Clocks with unrelated phase
   always #2 sys_clk = ~sys_clk;
   always begin
      #7 link_clk = 1'b1;
      #8 link_clk = 1'b0;
   end
   temp_limit_alert #(.CONV_CYC(CONV), .STBY_R0(SB[0]), .STBY_R1(SB[1]), .STBY_R2(SB[2]), .STBY_R3(SB[3]))
   u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
          .cmd_busy(cmd_busy), .rsp(rsp), .adc_code(adc_code), .sensor_enable(sensor_enable),
          .alert_pin(alert_pin));
   temp_host_model u_host (.link_clk(link_clk), .cmd_busy(cmd_busy), .rsp(rsp), .cmd_valid(cmd_valid),
                           .cmd(cmd));
   task automatic end_sim;
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Every request must be answered; a link that stays silent counts as a mismatch
   task automatic xf(input cmd_kind_t k, input logic [1:0] p, input logic [15:0] w);
      u_host.xfer(k, p, w, r);
      n_tests++;
      if (r.valid !== 1'b1) begin
         n_fail++;
         $display("Error at %0t: request not answered", $time);
      end
   endtask : xf
   task automatic rd(input logic [1:0] p, input logic [15:0] exp);
      xf(CMD_READ, p, 16'h0000);
      chk(r.data, exp);
   endtask : rd
   task automatic wr(input logic [1:0] p, input logic [15:0] w);
      xf(CMD_WRITE, p, w);
   endtask : wr
   task automatic al(input logic exp);
      chk({15'h0000, alert_pin}, {15'h0000, exp});
   endtask : al
   // Alert response; answer packed as hit and cause bit
   task automatic ares(input logic [15:0] exp);
      xf(CMD_ALERT, PTR_TEMP, 16'h0000);
      chk({14'h0000, r.hit, r.data[0]}, exp);
   endtask : ares
   // Bounded wait, so a stuck converter costs time but never hangs
   task automatic wait_lvl(input logic v);
      int n;
      n = 0;
      while (sensor_enable !== v && n < 300) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (sensor_enable !== v) begin
         n_fail++;
         $display("Error at %0t: sensor enable stuck", $time);
      end
   endtask : wait_lvl
   task automatic oneshot(input logic [11:0] a, input logic [15:0] c);
      @(posedge sys_clk);
      #1;
      adc_code = a;
      wr(PTR_CFG, c);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
   endtask : oneshot
   task automatic t_reset;
      rd(PTR_TEMP, 16'h0000);
      rd(PTR_CFG, CFG_RESET);
      rd(PTR_UPPER, {UPPER_RESET, 4'h0});
      rd(PTR_LOWER, {LOWER_RESET, 4'h0});
   endtask : t_reset
   task automatic t_format;
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      rd(PTR_TEMP, 16'h4B00);
      wr(PTR_TEMP, 16'h1230);
      adc_code = 12'hE70;
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      rd(PTR_TEMP, 16'hE700);
      wr(PTR_UPPER, 16'h190F);
      rd(PTR_UPPER, 16'h1900);
   endtask : t_format
   task automatic t_intr;
      adc_code = 12'h320;
      // Stop first; a conversion already running ends before shutdown, so only wait for it
      wr(PTR_CFG, 16'h2410);
      wait_lvl(1'b0);
      xf(CMD_READ, PTR_CFG, 16'h0000);
      al(1'b1);
      oneshot(12'h320, 16'h2510);
      al(1'b0);
      ares(16'h0003);
      al(1'b1);
      rd(PTR_CFG, 16'h3410);
      rd(PTR_CFG, 16'h2410);
   endtask : t_intr
   task automatic t_under;
      wr(PTR_LOWER, 16'h0000);
      wr(PTR_UPPER, 16'h7FF0);
      oneshot(12'hE70, 16'h2510);
      al(1'b0);
      ares(16'h0002);
      ares(16'h0000);
      rd(PTR_CFG, 16'h2C10);
   endtask : t_under
   task automatic t_pol;
      wr(PTR_CFG, 16'h2490);
      al(1'b0);
      oneshot(12'hE70, 16'h2590);
      al(1'b1);
      rd(PTR_CFG, 16'h2C90);
      al(1'b0);
   endtask : t_pol
   task automatic t_comp;
      wr(PTR_LOWER, 16'h8000);
      wr(PTR_UPPER, 16'h1900);
      oneshot(12'h191, 16'h2120);
      al(1'b0);
      rd(PTR_CFG, 16'h3020);
      al(1'b0);
      oneshot(12'h171, 16'h2120);
      al(1'b0);
      oneshot(12'h16F, 16'h2120);
      al(1'b1);
   endtask : t_comp
   task automatic t_gcrst;
      oneshot(12'h191, 16'h2120);
      xf(CMD_GCRST, PTR_TEMP, 16'h0000);
      chk({15'h0000, sensor_enable}, 16'h0001);
      al(1'b1);
      rd(PTR_CFG, CFG_RESET);
      rd(PTR_UPPER, {UPPER_RESET, 4'h0});
   endtask : t_gcrst
   // Standby length per rate, measured after the first conversion that ends after the write
   task automatic t_rate;
      int n;
      for (int i = 0; i < 4; i++) begin
         wr(PTR_CFG, 16'h0610 | (16'(i) << 13));
         wait_lvl(1'b1);
         wait_lvl(1'b0);
         n = 0;
         while (sensor_enable === 1'b0 && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
         end
         chk(16'(n + 2 >= SB[i] && n <= SB[i] + 2), 16'h0001);
      end
   endtask : t_rate
   initial begin
      repeat (5) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      t_reset();
      t_format();
      t_intr();
      t_under();
      t_pol();
      t_comp();
      t_gcrst();
      t_rate();
      end_sim();
   end
   // Watchdog well past the expected run
   initial begin
      #150000;
      $display("Error at %0t: watchdog expired", $time);
      n_fail++;
      end_sim();
   end
endmodule : temp_limit_alert_bench
